/* File: hdl/tw_consts.svh */
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH
`define TW_CLK_NS     20
`define TW_QTR_NS     2500
`define TW_QTR_CYC    ((`TW_QTR_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_EW_MS      10
`define TW_EW_CYC     (`TW_EW_MS * 1000000 / `TW_CLK_NS)
`define TW_MEM_DEPTH  256
`define TW_DEV_TYPE   4'ha
`define TW_LAST_BIT   4'h7
`define TW_ACK_BIT    4'h8
`define TW_PRE_BIT    4'hf
`define TW_BURST_MAX  4'h8
`define TW_WR_LIMIT   4'ha
`endif

/* File: hdl/tw_pkg.sv */
`include "tw_consts.svh"
package tw_pkg;
	typedef enum logic [2:0] {TW_D_IDLE, TW_D_ADDR, TW_D_WORD, TW_D_WDATA, TW_D_RDATA} tw_dev_state_t;
	typedef enum logic [1:0] {TW_M_IDLE, TW_M_START, TW_M_BIT, TW_M_STOP} tw_mst_state_t;
	typedef enum logic [2:0] {TW_CMD_START, TW_CMD_WRITE, TW_CMD_READ_ACK, TW_CMD_READ_NACK, TW_CMD_STOP} tw_cmd_t;
	typedef struct packed {
		tw_dev_state_t                   st;
		logic                            scl_m;
		logic                            scl;
		logic                            scl_d;
		logic                            sda_m;
		logic                            sda;
		logic                            sda_d;
		logic [2:0]                      strap_m;
		logic [2:0]                      strap;
		logic [3:0]                      cnt;
		logic [7:0]                      sh;
		logic                            rd;
		logic [7:0]                      ptr;
		logic [7:0]                      base;
		logic [3:0]                      nbuf;
		logic [7:0][7:0]                 wbuf;
		logic                            busy;
		logic [18:0]                     tmr;
		logic                            sda_oe_n;
		logic [`TW_MEM_DEPTH-1:0][7:0]   mem;
	} tw_dev_regs_t;
	typedef struct packed {
		tw_mst_state_t st;
		logic          scl_m;
		logic          scl;
		logic          sda_m;
		logic          sda;
		logic [6:0]    div;
		logic [1:0]    q;
		logic [3:0]    bitn;
		logic [7:0]    sh;
		logic          rdop;
		logic          ackdrv;
		logic          nacked;
		logic          active;
		logic [3:0]    wcnt;
		logic          scl_oe_n;
		logic          sda_oe_n;
		logic          rdy;
		logic          rv;
		logic [7:0]    rdata;
		logic          rack;
	} tw_mst_regs_t;
endpackage

/* File: hdl/tw_bus_if.sv */
`timescale 1ns/1ns
interface tw_bus_if;
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;
	logic scl;
	logic sda;
	// Open-drain wired-AND with pull-ups
	assign scl = m_scl_oe_n | m_scl_o;
	assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
	modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n, input scl, input sda);
	modport device (output d_sda_o, output d_sda_oe_n, input scl, input sda);
endinterface

/* File: hdl/tw_eeprom_target.sv */
`timescale 1ns/1ns
`include "tw_consts.svh"
// Summary of operation
// - Both lines high means bus idle
// - Master starts only on an idle bus
// - SDA fall with SCL high: start
// - SDA rise with SCL high: stop
// - SDA change during SCL high is control
// - One bit per pulse, change while low
// - Eight-bit bytes plus ninth acknowledge bit
// - Receiver drives low acknowledge, master clocks
// - Acknowledge stable low through high phase
// - Addressed device acknowledges every received byte except data bytes past the eighth and its address byte while busy
// - Master reader acknowledges all but last
// - Master ends read: no acknowledge, stop
// - Device releases SDA on master no-acknowledge
// - Write burst at most eight data bytes
// - Respond only when chip select matches straps
// - Erase/write cycle timed internally
// - Storage of 256 eight-bit bytes
// - Works from low to high clock rate
// - Chip select is low address bits
module tw_eeprom_target
	import tw_pkg::*;
#(
	parameter int EW_CYCLES = `TW_EW_CYC
)
(
	tw_bus_if.device  BUS,
	input  logic      CLK_I,
	input  logic      RSTN_I,
	input  logic      CHIP_SEL_STRAP_BIT0_I,
	input  logic      CHIP_SEL_STRAP_BIT1_I,
	input  logic      CHIP_SEL_STRAP_BIT2_I,
	output logic      BUSY_O
);
	tw_dev_regs_t r;
	tw_dev_regs_t next_r;
	logic         ev_start;
	logic         ev_stop;
	logic         ev_rise;
	logic         ev_fall;
	logic         addr_match;

	// Edges seen on synchronised copies; 50 MHz oversampling covers every bus rate
	assign ev_start   = r.scl & r.scl_d & r.sda_d & ~r.sda;
	assign ev_stop    = r.scl & r.scl_d & ~r.sda_d & r.sda;
	assign ev_rise    = r.scl & ~r.scl_d;
	assign ev_fall    = ~r.scl & r.scl_d;
	assign addr_match = (r.sh[7:4] == `TW_DEV_TYPE) && (r.sh[3:1] == r.strap) && !r.busy;

	always_comb
	begin
		next_r = r;
		next_r.scl_m = BUS.scl;
		next_r.scl = r.scl_m;
		next_r.scl_d = r.scl;
		next_r.sda_m = BUS.sda;
		next_r.sda = r.sda_m;
		next_r.sda_d = r.sda;
		next_r.strap_m = {CHIP_SEL_STRAP_BIT2_I, CHIP_SEL_STRAP_BIT1_I, CHIP_SEL_STRAP_BIT0_I};
		next_r.strap = r.strap_m;
		// Self-timed cycle, no bus clock needed
		if (r.busy)
		begin
			if (r.tmr == 19'(EW_CYCLES - 1))
			begin
				next_r.busy = 1'b0;
				next_r.tmr = 19'h0;
				for (int i = 0; i < 8; i++)
				begin
					if (4'(i) < r.nbuf)
					begin
						next_r.mem[8'(r.base + 8'(i))] = r.wbuf[i];
					end
				end
				next_r.nbuf = 4'h0;
			end
			else
			begin
				next_r.tmr = r.tmr + 19'h1;
			end
		end
		if (ev_start)
		begin
			next_r.st = TW_D_ADDR;
			// Start's own clock fall still to come; it must not count as a bit
			next_r.cnt = `TW_PRE_BIT;
			next_r.sda_oe_n = 1'b1;
		end
		else if (ev_stop)
		begin
			next_r.st = TW_D_IDLE;
			next_r.sda_oe_n = 1'b1;
			// Only a write closed by a stop is committed; a repeated start aborts it
			if (r.st == TW_D_WDATA && r.nbuf != 4'h0 && !r.busy)
			begin
				next_r.busy = 1'b1;
				next_r.tmr = 19'h0;
			end
		end
		else if (r.st == TW_D_RDATA)
		begin
			if (ev_rise && r.cnt == `TW_ACK_BIT && r.sda)
			begin
				next_r.st = TW_D_IDLE;
				next_r.sda_oe_n = 1'b1;
			end
			if (ev_fall)
			begin
				if (r.cnt < `TW_LAST_BIT)
				begin
					next_r.cnt = r.cnt + 4'h1;
					next_r.sh = {r.sh[6:0], 1'b0};
					next_r.sda_oe_n = r.sh[6];
				end
				else if (r.cnt == `TW_LAST_BIT)
				begin
					next_r.cnt = `TW_ACK_BIT;
					next_r.sda_oe_n = 1'b1;
				end
				else
				begin
					// Unlimited read: pointer just rolls over
					next_r.cnt = 4'h0;
					next_r.sh = r.mem[r.ptr];
					next_r.ptr = r.ptr + 8'h1;
					next_r.sda_oe_n = r.mem[r.ptr][7];
				end
			end
		end
		else if (r.st != TW_D_IDLE)
		begin
			if (ev_rise && r.cnt != `TW_ACK_BIT)
			begin
				next_r.sh = {r.sh[6:0], r.sda};
			end
			if (ev_fall)
			begin
				if (r.cnt == `TW_PRE_BIT)
				begin
					next_r.cnt = 4'h0;
				end
				else if (r.cnt < `TW_LAST_BIT)
				begin
					next_r.cnt = r.cnt + 4'h1;
				end
				else if (r.cnt == `TW_LAST_BIT)
				begin
					next_r.cnt = `TW_ACK_BIT;
					if (r.st == TW_D_ADDR)
					begin
						if (addr_match)
						begin
							next_r.sda_oe_n = 1'b0;
							next_r.rd = r.sh[0];
						end
						else
						begin
							next_r.st = TW_D_IDLE;
						end
					end
					else if (r.st == TW_D_WORD)
					begin
						next_r.sda_oe_n = 1'b0;
						next_r.ptr = r.sh;
						next_r.base = r.sh;
						next_r.nbuf = 4'h0;
					end
					else if (r.nbuf < `TW_BURST_MAX)
					begin
						next_r.sda_oe_n = 1'b0;
						next_r.wbuf[r.nbuf[2:0]] = r.sh;
						next_r.nbuf = r.nbuf + 4'h1;
						next_r.ptr = r.ptr + 8'h1;
					end
					// A ninth data byte is left unacknowledged and dropped
					else
					begin
						next_r.sda_oe_n = 1'b1;
					end
				end
				else
				begin
					// Ack held until SCL is low again
					next_r.cnt = 4'h0;
					next_r.sda_oe_n = 1'b1;
					if (r.st == TW_D_ADDR && r.rd)
					begin
						next_r.st = TW_D_RDATA;
						next_r.sh = r.mem[r.ptr];
						next_r.ptr = r.ptr + 8'h1;
						next_r.sda_oe_n = r.mem[r.ptr][7];
					end
					else if (r.st == TW_D_ADDR)
					begin
						next_r.st = TW_D_WORD;
					end
					else
					begin
						next_r.st = TW_D_WDATA;
					end
				end
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			r <= '0;
			r.sda_oe_n <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign BUS.d_sda_o = 1'b0;
	assign BUS.d_sda_oe_n = r.sda_oe_n;
	assign BUSY_O = r.busy;
endmodule // tw_eeprom_target

/* File: hdl/tw_bus_master.sv */
`timescale 1ns/1ns
`include "tw_consts.svh"
module tw_bus_master
	import tw_pkg::*;
(
	tw_bus_if.master  BUS,
	input  logic      CLK_I,
	input  logic      RSTN_I,
	input  logic      CMD_VALID_I,
	input  tw_cmd_t   CMD_OP_I,
	input  logic [7:0] CMD_DATA_I,
	output logic      CMD_READY_O,
	output logic      RSP_VALID_O,
	output logic [7:0] RSP_DATA_O,
	output logic      RSP_ACK_O,
	output logic      BUS_ACTIVE_O
);
	tw_mst_regs_t r;
	tw_mst_regs_t next_r;
	logic         tick;
	logic         refuse;

	assign tick = (r.div == 7'(`TW_QTR_CYC - 1));
	// After a closing no-acknowledge only start or stop may follow
	assign refuse = !r.active || r.nacked || (CMD_OP_I == TW_CMD_WRITE && r.wcnt >= `TW_WR_LIMIT);

	always_comb
	begin
		next_r = r;
		next_r.scl_m = BUS.scl;
		next_r.scl = r.scl_m;
		next_r.sda_m = BUS.sda;
		next_r.sda = r.sda_m;
		next_r.rv = 1'b0;
		next_r.div = (r.st == TW_M_IDLE || tick) ? 7'h0 : r.div + 7'h1;
		unique case (r.st)
			TW_M_IDLE:
			begin
				if (CMD_VALID_I && r.rdy)
				begin
					next_r.rdy = 1'b0;
					next_r.q = 2'h0;
					next_r.bitn = 4'h0;
					if (CMD_OP_I == TW_CMD_START)
					begin
						if (r.active || (r.scl && r.sda))
						begin
							next_r.st = TW_M_START;
						end
						else
						begin
							next_r.rv = 1'b1;
							next_r.rack = 1'b0;
							next_r.rdy = 1'b1;
						end
					end
					else if (CMD_OP_I == TW_CMD_STOP)
					begin
						if (r.active)
						begin
							next_r.st = TW_M_STOP;
						end
						else
						begin
							next_r.rv = 1'b1;
							next_r.rack = 1'b1;
							next_r.rdy = 1'b1;
						end
					end
					else if (refuse)
					begin
						next_r.rv = 1'b1;
						next_r.rack = 1'b0;
						next_r.rdy = 1'b1;
					end
					else
					begin
						next_r.st = TW_M_BIT;
						next_r.rdop = (CMD_OP_I != TW_CMD_WRITE);
						next_r.ackdrv = (CMD_OP_I == TW_CMD_READ_ACK);
						next_r.sh = CMD_DATA_I;
						if (CMD_OP_I == TW_CMD_WRITE)
						begin
							next_r.wcnt = r.wcnt + 4'h1;
						end
					end
				end
			end
			TW_M_START:
			begin
				if (tick)
				begin
					next_r.q = r.q + 2'h1;
					unique case (r.q)
						2'h0: next_r.sda_oe_n = 1'b1;
						2'h1: next_r.scl_oe_n = 1'b1;
						2'h2: next_r.sda_oe_n = 1'b0;
						2'h3:
						begin
							next_r.scl_oe_n = 1'b0;
							next_r.active = 1'b1;
							next_r.nacked = 1'b0;
							next_r.wcnt = 4'h0;
							next_r.st = TW_M_IDLE;
							next_r.rv = 1'b1;
							next_r.rack = 1'b1;
							next_r.rdy = 1'b1;
						end
					endcase
				end
			end
			TW_M_BIT:
			begin
				if (tick)
				begin
					next_r.q = r.q + 2'h1;
					unique case (r.q)
						2'h0:
						begin
							// SDA moves only in the low phase
							if (r.bitn == `TW_ACK_BIT)
							begin
								next_r.sda_oe_n = r.rdop ? ~r.ackdrv : 1'b1;
							end
							else
							begin
								next_r.sda_oe_n = r.rdop ? 1'b1 : r.sh[7];
							end
						end
						2'h1: next_r.scl_oe_n = 1'b1;
						2'h2:
						begin
							if (r.bitn == `TW_ACK_BIT)
							begin
								next_r.rack = ~r.sda;
							end
							else
							begin
								next_r.sh = {r.sh[6:0], r.sda};
							end
						end
						2'h3:
						begin
							next_r.scl_oe_n = 1'b0;
							if (r.bitn == `TW_ACK_BIT)
							begin
								next_r.st = TW_M_IDLE;
								next_r.sda_oe_n = 1'b1;
								next_r.rdata = r.sh;
								next_r.nacked = r.rdop && !r.ackdrv;
								next_r.rv = 1'b1;
								next_r.rdy = 1'b1;
							end
							else
							begin
								next_r.bitn = r.bitn + 4'h1;
							end
						end
					endcase
				end
			end
			TW_M_STOP:
			begin
				if (tick)
				begin
					next_r.q = r.q + 2'h1;
					unique case (r.q)
						2'h0: next_r.sda_oe_n = 1'b0;
						2'h1: next_r.scl_oe_n = 1'b1;
						2'h2: next_r.sda_oe_n = 1'b1;
						2'h3:
						begin
							next_r.active = 1'b0;
							next_r.nacked = 1'b0;
							next_r.st = TW_M_IDLE;
							next_r.rv = 1'b1;
							next_r.rack = 1'b1;
							next_r.rdy = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			r <= '0;
			r.scl_oe_n <= 1'b1;
			r.sda_oe_n <= 1'b1;
			r.rdy <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign BUS.m_scl_o = 1'b0;
	assign BUS.m_sda_o = 1'b0;
	assign BUS.m_scl_oe_n = r.scl_oe_n;
	assign BUS.m_sda_oe_n = r.sda_oe_n;
	assign CMD_READY_O = r.rdy;
	assign RSP_VALID_O = r.rv;
	assign RSP_DATA_O = r.rdata;
	assign RSP_ACK_O = r.rack;
	assign BUS_ACTIVE_O = r.active;
endmodule // tw_bus_master

/* File: tb/tw_bus_monitor.sv */
`timescale 1ns/1ns
module tw_bus_monitor
#(
	parameter int EW_CYCLES = 200
)
(
	input logic CLK_I,
	input logic RSTN_I,
	input logic BUSY_O,
	input logic m_scl_o,
	input logic m_scl_oe_n,
	input logic m_sda_o,
	input logic m_sda_oe_n,
	input logic d_sda_o,
	input logic d_sda_oe_n,
	input logic scl,
	input logic sda
);
	typedef struct packed {
		logic        act;
		logic        scl_q;
		logic        sda_q;
		logic [19:0] cnt;
	} tw_mon_regs_t;
	tw_mon_regs_t r;
	tw_mon_regs_t next_r;
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// Transfer state taken from the wire alone, not from either end
	always_comb
	begin
		next_r       = r;
		next_r.scl_q = scl;
		next_r.sda_q = sda;
		next_r.cnt   = BUSY_O ? r.cnt + 20'h1 : 20'h0;
		if (scl && r.scl_q && r.sda_q && !sda)
			next_r.act = 1'b1;
		else if (scl && r.scl_q && !r.sda_q && sda)
			next_r.act = 1'b0;
	end
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			r <= '0;
		else
			r <= next_r;
	end
	a_oe_steady_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
		else $error("device enable moved with clock high");
	a_drive_after_fall: assert property ($changed(d_sda_oe_n) |->
		!scl && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
		else $error("device enable moved away from clock fall");
	a_ack_holds: assert property ($fell(d_sda_oe_n) |-> !d_sda_oe_n [*8])
		else $error("device low drive too short");
	a_release_holds: assert property ($rose(d_sda_oe_n) |-> d_sda_oe_n [*8])
		else $error("device release too short");
	a_quiet_outside: assert property (!r.act |-> d_sda_oe_n)
		else $error("device drives outside a transfer");
	a_busy_after_stop: assert property ($rose(BUSY_O) |-> !r.act && scl && sda)
		else $error("busy began without a stop");
	a_busy_length: assert property ($fell(BUSY_O) |->
		r.cnt >= EW_CYCLES - 1 && r.cnt <= EW_CYCLES + 1)
		else $error("busy length wrong");
	a_busy_silent: assert property (BUSY_O |-> d_sda_oe_n)
		else $error("device drives while busy");
	cover property ($rose(BUSY_O));
	cover property ($fell(d_sda_oe_n));
	cover property ($fell(r.act));
endmodule // tw_bus_monitor

/* File: tb/two_wire_eeprom_slave_port_test.sv */
`timescale 1ns/1ns
module two_wire_eeprom_slave_port_test
	import tw_pkg::*;
;
	localparam int EW = 6000;
	logic        clk;
	logic        rst_n;
	logic [2:0]  strap;
	logic        busy;
	logic        cmd_valid;
	tw_cmd_t     cmd_op;
	logic [7:0]  cmd_data;
	logic        cmd_ready;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        rsp_ack;
	logic        bus_active;
	logic        scl_q;
	logic [8:0]  wire_sh;
	logic [10:0] e;
	logic [10:0] exp_q[$];
	logic [7:0]  w;
	logic [7:0]  d[8];
	int          n;
	int          fail_count;
	int          n_checks;
	tw_bus_if bus();
	tw_eeprom_target #(.EW_CYCLES(EW)) tw_eeprom_target_inst (.BUS(bus.device), .CLK_I(clk), .RSTN_I(rst_n),
		.CHIP_SEL_STRAP_BIT0_I(strap[0]), .CHIP_SEL_STRAP_BIT1_I(strap[1]), .CHIP_SEL_STRAP_BIT2_I(strap[2]),
		.BUSY_O(busy));
	tw_bus_master tw_bus_master_inst (.BUS(bus.master), .CLK_I(clk), .RSTN_I(rst_n), .CMD_VALID_I(cmd_valid),
		.CMD_OP_I(cmd_op), .CMD_DATA_I(cmd_data), .CMD_READY_O(cmd_ready), .RSP_VALID_O(rsp_valid),
		.RSP_DATA_O(rsp_data), .RSP_ACK_O(rsp_ack), .BUS_ACTIVE_O(bus_active));
	tw_bus_monitor #(.EW_CYCLES(EW)) tw_bus_monitor_inst (.CLK_I(clk), .RSTN_I(rst_n), .BUSY_O(busy),
		.m_scl_o(bus.m_scl_o), .m_scl_oe_n(bus.m_scl_oe_n), .m_sda_o(bus.m_sda_o), .m_sda_oe_n(bus.m_sda_oe_n),
		.d_sda_o(bus.d_sda_o), .d_sda_oe_n(bus.d_sda_oe_n), .scl(bus.scl), .sda(bus.sda));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task check(input string what, input logic [8:0] seen, input logic [8:0] expd);
		n_checks++;
		if (seen !== expd)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, expd, seen);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task cmd(input tw_cmd_t op, input logic [7:0] dat, input logic wchk, input logic dchk, input logic ack);
		int i;
		exp_q.push_back({wchk, dchk, dat, ack});
		cmd_valid <= 1'b1;
		cmd_op    <= op;
		cmd_data  <= dat;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (cmd_ready !== 1'b1 && i < 10);
		if (cmd_ready !== 1'b1)
		begin
			fail_count++;
			report_and_stop;
		end
		cmd_valid <= 1'b0;
		for (i = 0; i < 5000 && rsp_valid !== 1'b1; i++)
			@(posedge clk);
		if (i == 5000)
		begin
			fail_count++;
			report_and_stop;
		end
	endtask
	task wr(input logic [7:0] dat, input logic wchk, input logic ack);
		cmd(TW_CMD_WRITE, dat, wchk, 1'b0, ack);
	endtask
	task ctl(input tw_cmd_t op);
		cmd(op, 8'h00, 1'b0, 1'b0, 1'b1);
	endtask
	// Bytes rebuilt from the wire at each clock rise, ack bit last
	always @(posedge clk)
	begin
		scl_q <= bus.scl;
		if (bus.scl === 1'b1 && scl_q === 1'b0)
			wire_sh <= {wire_sh[7:0], bus.sda};
		if (rsp_valid === 1'b1 && exp_q.size() == 0)
			check("queue", 9'h000, 9'h001);
		else if (rsp_valid === 1'b1)
		begin
			e = exp_q.pop_front();
			check("ack", {8'h00, rsp_ack}, {8'h00, e[0]});
			if (e[9])
				check("data", {1'b0, rsp_data}, {1'b0, e[8:1]});
			if (e[10])
				check("wire", wire_sh, {e[8:1], ~e[0]});
		end
	end
	initial
	begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = TW_CMD_STOP;
		cmd_data = 8'h00;
		fail_count = 0;
		n_checks = 0;
		scl_q = 1'b1;
		wire_sh = 9'h000;
		void'($urandom(32'hca09));
		strap = 3'($urandom);
		w = 8'($urandom);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		check("idle", {7'h00, bus.scl, bus.sda}, 9'h003);
		wr(8'h55, 1'b0, 1'b0);
		ctl(TW_CMD_START);
		check("active", {8'h00, bus_active}, 9'h001);
		wr({4'ha, strap, 1'b0}, 1'b1, 1'b1);
		wr(w, 1'b1, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			d[i] = 8'($urandom);
			wr(d[i], 1'b1, 1'b1);
		end
		wr(8'h00, 1'b0, 1'b0);
		ctl(TW_CMD_STOP);
		check("busy", {7'h00, busy, bus.scl}, 9'h003);
		ctl(TW_CMD_START);
		wr({4'ha, strap, 1'b0}, 1'b1, 1'b0);
		ctl(TW_CMD_STOP);
		for (n = 0; n < 8000 && busy !== 1'b0; n++)
			@(posedge clk);
		check("busy", {8'h00, busy}, 9'h000);
		for (int j = 0; j < 2; j++)
		begin
			ctl(TW_CMD_START);
			wr(j ? {4'h5, strap, 1'b0} : {4'ha, strap ^ 3'h1, 1'b0}, 1'b1, 1'b0);
			ctl(TW_CMD_STOP);
		end
		ctl(TW_CMD_START);
		wr({4'ha, strap, 1'b0}, 1'b1, 1'b1);
		wr(w + 8'h06, 1'b1, 1'b1);
		ctl(TW_CMD_START);
		wr({4'ha, strap, 1'b1}, 1'b1, 1'b1);
		cmd(TW_CMD_READ_ACK, d[6], 1'b1, 1'b1, 1'b1);
		cmd(TW_CMD_READ_NACK, d[7], 1'b1, 1'b1, 1'b0);
		ctl(TW_CMD_STOP);
		check("active", {8'h00, bus_active}, 9'h000);
		repeat (2) @(posedge clk);
		report_and_stop;
	end
endmodule // two_wire_eeprom_slave_port_test
